//--- power_mode_pkg.sv
package power_mode_pkg;

  localparam logic [3:0] addr_protection = 4'h0;
  localparam logic [3:0] addr_control = 4'h4;
  localparam logic [3:0] addr_state = 4'h8;
  localparam logic [3:0] addr_handshake = 4'hc;

  localparam int run_select_lsb = 5;
  localparam int halt_select_lsb = 0;
  localparam int aborted_bit = 3;
  localparam int allow_vlp_bit = 5;

  localparam logic [1:0] run_select_normal = 2'h0;
  localparam logic [1:0] run_select_vlp = 2'h2;
  localparam logic [2:0] halt_select_normal = 3'h0;
  localparam logic [2:0] halt_select_vlp = 3'h2;

  localparam logic [7:0] state_code_run = 8'h01;
  localparam logic [7:0] state_code_halt = 8'h02;
  localparam logic [7:0] state_code_very_low_power_run = 8'h04;
  localparam logic [7:0] state_code_very_low_power_wait = 8'h08;
  localparam logic [7:0] state_code_very_low_power_halt = 8'h10;
  localparam logic [7:0] state_code_wait = 8'h20;

  localparam logic [31:0] reset_stack_offset = 32'h00000000;
  localparam logic [31:0] reset_pc_offset = 32'h00000004;
  localparam logic [31:0] reset_link_value = 32'hffffffff;

  typedef enum logic [13:0] {
    st_run        = 14'h0001,
    st_very_low_power_run       = 14'h0002,
    st_wait       = 14'h0004,
    st_very_low_power_wait       = 14'h0008,
    st_ent_cpu    = 14'h0010,
    st_ent_master = 14'h0020,
    st_ent_slave  = 14'h0040,
    st_ent_clock  = 14'h0080,
    st_ent_reg    = 14'h0100,
    st_halted     = 14'h0200,
    st_ex_reg     = 14'h0400,
    st_ex_clock   = 14'h0800,
    st_ex_bus     = 14'h1000,
    st_ex_cpu     = 14'h2000
  } mode_state_type;

endpackage : power_mode_pkg

//--- system_power_mode_controller.sv
`timescale 1ns/1ps
module system_power_mode_controller
  import power_mode_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Processor core.
  input wire logic sleep_request,
  input wire logic deep_sleep_select,
  input wire logic wake_interrupt,
  input wire logic debug_enable,
  input wire logic debug_halt_request,
  // Stop handshakes.
  input wire logic master_stop_ack,
  input wire logic slave_stop_ack,
  input wire logic regulator_run_ready,
  input wire logic regulator_stop_ready,
  // Controls driven out.
  output logic cpu_clock_enable,
  output logic bus_clock_enable,
  output logic stop_in_wait_clock_enable,
  output logic clock_generator_enable,
  output logic regulator_stop_request,
  output logic master_stop_request,
  output logic slave_stop_request,
  output logic flash_program_allowed,
  output logic [31:0] vector_stack_address,
  output logic [31:0] vector_pc_address,
  output logic [31:0] link_register_init
);

  logic [6:0] pin_sync_a;
  logic [6:0] pin_sync_b;
  logic sleep_req;
  logic deep_sleep;
  logic dbg_enable;
  logic dbg_halt;
  logic wake_irq;
  logic reg_run_rdy;
  logic reg_stop_rdy;

  mode_state_type state;
  mode_state_type next_state;
  logic allow_very_low_power;
  logic next_allow_very_low_power;
  logic [1:0] run_mode_select;
  logic [1:0] next_run_mode_select;
  logic [2:0] halt_mode_select;
  logic [2:0] next_halt_mode_select;
  logic entry_aborted_flag;
  logic next_entry_aborted_flag;
  logic target_vlp_halt;
  logic next_target_vlp_halt;
  logic vlp_exit_blocked;
  logic next_vlp_exit_blocked;
  logic [7:0] power_mode_state;
  logic [7:0] next_power_mode_state;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic access_pending;
  logic next_access_pending;
  logic in_vlp;
  logic halt_allowed;
  logic next_stop_regulation;

  // Core, debug and regulator signals come from other timing; two stages before any use.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_a <= 7'h00;
      pin_sync_b <= 7'h00;
    end
    else
    begin
      pin_sync_a <= {sleep_request, wake_interrupt, regulator_run_ready, regulator_stop_ready,
        deep_sleep_select, debug_enable, debug_halt_request};
      pin_sync_b <= pin_sync_a;
    end
  end

  assign sleep_req = pin_sync_b[6];
  assign wake_irq = pin_sync_b[5];
  assign reg_run_rdy = pin_sync_b[4];
  assign reg_stop_rdy = pin_sync_b[3];
  assign deep_sleep = pin_sync_b[2];
  assign dbg_enable = pin_sync_b[1];
  assign dbg_halt = pin_sync_b[0];

  function automatic logic [7:0] state_code(input mode_state_type s);
    case (s)
      st_run: state_code = state_code_run;
      st_very_low_power_run: state_code = state_code_very_low_power_run;
      st_wait: state_code = state_code_wait;
      st_very_low_power_wait: state_code = state_code_very_low_power_wait;
      st_ent_reg: state_code = state_code_halt;
      st_halted: state_code = state_code_halt;
      default: state_code = state_code_halt;
    endcase
  endfunction : state_code

  assign in_vlp = (state == st_very_low_power_run) || (state == st_very_low_power_wait);
  // A halt request counts only while the debugger is enabled.
  assign halt_allowed = dbg_enable && dbg_halt;

  always_comb
  begin
    next_state = state;
    next_allow_very_low_power = allow_very_low_power;
    next_run_mode_select = run_mode_select;
    next_halt_mode_select = halt_mode_select;
    next_entry_aborted_flag = entry_aborted_flag;
    next_target_vlp_halt = target_vlp_halt;
    next_vlp_exit_blocked = vlp_exit_blocked;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    next_access_pending = 1'b0;

    // Bus: the take edge latches read data and lowers waitrequest for one cycle. A write
    // commits only at the next edge, where the master samples waitrequest low.
    if (read || write)
    begin
      if (!access_pending)
      begin
        next_access_pending = 1'b1;
        next_waitrequest = 1'b0;
      end
      if (address == addr_protection)
      begin
        next_readdata = {26'h0, allow_very_low_power, 5'h0};
        if (write && access_pending)
        begin
          next_allow_very_low_power = allow_very_low_power | writedata[allow_vlp_bit];
        end
      end
      else if (address == addr_control)
      begin
        next_readdata = {25'h0, run_mode_select, 1'b0, entry_aborted_flag, halt_mode_select};
        if (write && access_pending)
        begin
          next_halt_mode_select = writedata[halt_select_lsb +: 3];
          if (writedata[run_select_lsb +: 2] != run_select_vlp || allow_very_low_power)
          begin
            next_run_mode_select = writedata[run_select_lsb +: 2];
          end
        end
      end
      else if (address == addr_state)
      begin
        next_readdata = {24'h0, power_mode_state};
      end
      else
      begin
        next_readdata = 32'h0;
      end
    end

    case (state)
      st_run:
      begin
        if (run_mode_select == run_select_vlp && allow_very_low_power)
        begin
          next_state = st_very_low_power_run;
        end
        else if (sleep_req && !deep_sleep)
        begin
          next_state = st_wait;
        end
        else if (sleep_req && deep_sleep)
        begin
          next_target_vlp_halt = allow_very_low_power && halt_mode_select == halt_select_vlp;
          next_vlp_exit_blocked = 1'b1;
          next_state = st_ent_cpu;
        end
      end
      st_very_low_power_run:
      begin
        // The regulator is released as soon as the select leaves VLP run; run waits for it.
        if (run_mode_select != run_select_vlp && reg_run_rdy)
        begin
          next_state = st_run;
        end
        else if (sleep_req && !deep_sleep)
        begin
          next_state = st_very_low_power_wait;
        end
        else if (sleep_req && deep_sleep)
        begin
          next_target_vlp_halt = halt_mode_select == halt_select_vlp
            || halt_mode_select == halt_select_normal;
          next_vlp_exit_blocked = 1'b0;
          next_state = st_ent_cpu;
        end
      end
      // A debug halt brings the processor and stop-in-wait clocks back; the stop handshakes stay idle.
      st_wait:
      begin
        if (wake_irq || halt_allowed)
        begin
          next_state = st_run;
        end
      end
      st_very_low_power_wait:
      begin
        if (wake_irq || halt_allowed)
        begin
          next_state = st_very_low_power_run;
        end
      end
      st_ent_cpu, st_ent_master, st_ent_slave, st_ent_clock:
      begin
        if (wake_irq)
        begin
          next_state = st_run;
          next_entry_aborted_flag = 1'b1;
          next_run_mode_select = run_select_normal;
        end
        else if (state == st_ent_cpu)
        begin
          next_state = st_ent_master;
        end
        else if (state == st_ent_master && master_stop_ack)
        begin
          next_state = st_ent_slave;
        end
        else if (state == st_ent_slave && slave_stop_ack)
        begin
          next_state = st_ent_clock;
        end
        else if (state == st_ent_clock)
        begin
          next_state = st_ent_reg;
        end
      end
      st_ent_reg:
      begin
        if (reg_stop_rdy || !target_vlp_halt)
        begin
          next_state = st_halted;
        end
      end
      st_halted:
      begin
        if (wake_irq || halt_allowed)
        begin
          next_state = st_ex_reg;
        end
      end
      st_ex_reg:
      begin
        // A return to VLP run keeps stop regulation; a return to run waits for run regulation.
        if (reg_run_rdy || (target_vlp_halt && !vlp_exit_blocked))
        begin
          next_state = st_ex_clock;
        end
      end
      st_ex_clock: next_state = st_ex_bus;
      st_ex_bus: next_state = st_ex_cpu;
      st_ex_cpu:
      begin
        if (target_vlp_halt && !vlp_exit_blocked)
        begin
          next_state = st_very_low_power_run;
        end
        else
        begin
          next_state = st_run;
          next_run_mode_select = run_select_normal;
        end
      end
      default: next_state = st_run;
    endcase

    next_power_mode_state = state_code(next_state);
    if (next_state == st_ent_reg && !next_target_vlp_halt)
    begin
      next_power_mode_state = state_code_halt;
    end
    if (next_state == st_halted && next_target_vlp_halt)
    begin
      next_power_mode_state = state_code_very_low_power_halt;
    end

    // Stop regulation is kept across a VLP stop that starts and ends in VLP run.
    next_stop_regulation = (next_state == st_very_low_power_wait)
      || (next_state == st_very_low_power_run && next_run_mode_select == run_select_vlp)
      || (next_target_vlp_halt && (next_state inside {st_ent_reg, st_halted}))
      || (next_target_vlp_halt && !next_vlp_exit_blocked && (next_state inside {st_ent_cpu,
      st_ent_master, st_ent_slave, st_ent_clock, st_ex_reg, st_ex_clock, st_ex_bus, st_ex_cpu}));
  end

  // Reset drives all state to normal run with the reset vectors presented.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= st_run;
      allow_very_low_power <= 1'b0;
      run_mode_select <= run_select_normal;
      halt_mode_select <= halt_select_normal;
      entry_aborted_flag <= 1'b0;
      target_vlp_halt <= 1'b0;
      vlp_exit_blocked <= 1'b0;
      power_mode_state <= state_code_run;
      readdata <= 32'h0;
      waitrequest <= 1'b1;
      access_pending <= 1'b0;
      cpu_clock_enable <= 1'b1;
      bus_clock_enable <= 1'b1;
      stop_in_wait_clock_enable <= 1'b1;
      clock_generator_enable <= 1'b1;
      regulator_stop_request <= 1'b0;
      master_stop_request <= 1'b0;
      slave_stop_request <= 1'b0;
      flash_program_allowed <= 1'b1;
      vector_stack_address <= reset_stack_offset;
      vector_pc_address <= reset_pc_offset;
      link_register_init <= reset_link_value;
    end
    else
    begin
      state <= next_state;
      allow_very_low_power <= next_allow_very_low_power;
      run_mode_select <= next_run_mode_select;
      halt_mode_select <= next_halt_mode_select;
      entry_aborted_flag <= next_entry_aborted_flag;
      target_vlp_halt <= next_target_vlp_halt;
      vlp_exit_blocked <= next_vlp_exit_blocked;
      power_mode_state <= next_power_mode_state;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      access_pending <= next_access_pending;
      cpu_clock_enable <= (next_state == st_run) || (next_state == st_very_low_power_run);
      bus_clock_enable <= !(next_state inside {st_ent_clock, st_ent_reg, st_halted,
        st_ex_reg, st_ex_clock});
      stop_in_wait_clock_enable <= (next_state == st_run) || (next_state == st_very_low_power_run);
      clock_generator_enable <= !(next_state inside {st_ent_reg, st_halted, st_ex_reg});
      regulator_stop_request <= next_stop_regulation;
      master_stop_request <= next_state inside {st_ent_master, st_ent_slave, st_ent_clock,
        st_ent_reg, st_halted};
      slave_stop_request <= next_state inside {st_ent_slave, st_ent_clock, st_ent_reg,
        st_halted};
      flash_program_allowed <= !next_stop_regulation;
      vector_stack_address <= reset_stack_offset;
      vector_pc_address <= reset_pc_offset;
      link_register_init <= reset_link_value;
    end
  end

endmodule : system_power_mode_controller

//--- system_power_mode_controller_properties.sv
`timescale 1ns/1ps
module power_mode_checker
(
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic waitrequest,
  // Handshakes and controls.
  input wire logic master_stop_ack,
  input wire logic cpu_clock_enable,
  input wire logic bus_clock_enable,
  input wire logic stop_in_wait_clock_enable,
  input wire logic clock_generator_enable,
  input wire logic regulator_stop_request,
  input wire logic slave_stop_request,
  input wire logic flash_program_allowed,
  // Reset vectors.
  input wire logic [31:0] vector_stack_address,
  input wire logic [31:0] vector_pc_address,
  input wire logic [31:0] link_register_init
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  reset_vectors_a: assert property (
    vector_stack_address == 32'h0 && vector_pc_address == 32'h4
    && link_register_init == 32'hffffffff) else $error("reset vectors wrong");
  master_then_slave_a: assert property (
    $rose(slave_stop_request) |-> $past(master_stop_ack)) else $error("slave asked early");
  cpu_before_bus_a: assert property (
    $fell(bus_clock_enable) |-> !cpu_clock_enable) else $error("bus gated before cpu");
  bus_before_gen_a: assert property (
    $fell(clock_generator_enable) |-> !bus_clock_enable) else $error("generator off early");
  gen_before_bus_a: assert property (
    $rose(bus_clock_enable) |-> clock_generator_enable) else $error("bus on before generator");
  bus_before_cpu_a: assert property (
    $rose(cpu_clock_enable) |-> bus_clock_enable && clock_generator_enable)
    else $error("cpu clock on too early");
  wait_gating_a: assert property (
    !stop_in_wait_clock_enable |-> !cpu_clock_enable) else $error("stop-in-wait gated in run");
  regulator_hold_a: assert property (
    $rose(regulator_stop_request) |-> regulator_stop_request [*3])
    else $error("regulator request dropped");
  flash_refused_a: assert property (
    (regulator_stop_request && cpu_clock_enable) [*2] |-> !flash_program_allowed)
    else $error("flash allowed in low power run");
  answer_single_a: assert property (
    !waitrequest |=> waitrequest) else $error("answer longer than one cycle");
endmodule : power_mode_checker

bind system_power_mode_controller power_mode_checker chk_u (.clk(clk), .rst_n(rst_n),
  .waitrequest(waitrequest), .master_stop_ack(master_stop_ack),
  .cpu_clock_enable(cpu_clock_enable), .bus_clock_enable(bus_clock_enable),
  .stop_in_wait_clock_enable(stop_in_wait_clock_enable),
  .clock_generator_enable(clock_generator_enable),
  .regulator_stop_request(regulator_stop_request), .slave_stop_request(slave_stop_request),
  .flash_program_allowed(flash_program_allowed), .vector_stack_address(vector_stack_address),
  .vector_pc_address(vector_pc_address), .link_register_init(link_register_init));

//--- power_partner_model.sv
`timescale 1ns/1ps
module power_partner_model
(
  // Clock, reset and answer speed.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Requests from the controller.
  input wire logic master_stop_request,
  input wire logic slave_stop_request,
  input wire logic regulator_stop_request,
  // Answers.
  output logic master_stop_ack,
  output logic slave_stop_ack,
  output logic regulator_run_ready,
  output logic regulator_stop_ready
);
  logic [1:0] bus_q;
  logic reg_q;
  logic [4:0] bus_age;
  logic [4:0] reg_age;
  logic [4:0] delay;
  logic bus_same;
  logic reg_same;
  // Any change of request restarts the count, so no answer is ever given at once.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bus_q <= 2'h0;
      reg_q <= 1'b0;
      bus_age <= 5'h0;
      reg_age <= 5'h0;
    end
    else
    begin
      bus_q <= {slave_stop_request, master_stop_request};
      reg_q <= regulator_stop_request;
      bus_age <= (bus_q != {slave_stop_request, master_stop_request}) ? 5'h0 :
        (bus_age == 5'h1f ? bus_age : bus_age + 5'h1);
      reg_age <= (reg_q != regulator_stop_request) ? 5'h0 :
        (reg_age == 5'h1f ? reg_age : reg_age + 5'h1);
    end
  assign delay = slow ? 5'h14 : 5'h01;
  assign bus_same = bus_q == {slave_stop_request, master_stop_request};
  assign reg_same = reg_q == regulator_stop_request;
  assign master_stop_ack = master_stop_request && bus_same && bus_age >= delay;
  assign slave_stop_ack = slave_stop_request && bus_same && bus_age >= delay;
  assign regulator_stop_ready = regulator_stop_request && reg_same && reg_age >= delay;
  assign regulator_run_ready = !regulator_stop_request && reg_same && reg_age >= delay;
endmodule : power_partner_model

//--- tb_system_power_mode_controller.sv
`timescale 1ns/1ps
module tb_system_power_mode_controller;
  import power_mode_pkg::*;
  logic clk, rst_n, read, write, sleep_request, deep_sleep_select, wake_interrupt, slow;
  logic debug_enable, debug_halt_request, waitrequest, cpu_clock_enable, bus_clock_enable;
  logic stop_in_wait_clock_enable, clock_generator_enable, regulator_stop_request;
  logic master_stop_request, slave_stop_request, flash_program_allowed, master_stop_ack;
  logic slave_stop_ack, regulator_run_ready, regulator_stop_ready;
  logic [3:0] address;
  logic [31:0] writedata, readdata, vector_stack_address, vector_pc_address;
  logic [31:0] link_register_init, rd;
  int n_fail = 0, checks = 0, cycles = 0;

  system_power_mode_controller dut_u (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_request(sleep_request),
    .deep_sleep_select(deep_sleep_select), .wake_interrupt(wake_interrupt),
    .debug_enable(debug_enable), .debug_halt_request(debug_halt_request),
    .master_stop_ack(master_stop_ack), .slave_stop_ack(slave_stop_ack),
    .regulator_run_ready(regulator_run_ready), .regulator_stop_ready(regulator_stop_ready),
    .cpu_clock_enable(cpu_clock_enable), .bus_clock_enable(bus_clock_enable),
    .stop_in_wait_clock_enable(stop_in_wait_clock_enable),
    .clock_generator_enable(clock_generator_enable),
    .regulator_stop_request(regulator_stop_request), .master_stop_request(master_stop_request),
    .slave_stop_request(slave_stop_request), .flash_program_allowed(flash_program_allowed),
    .vector_stack_address(vector_stack_address), .vector_pc_address(vector_pc_address),
    .link_register_init(link_register_init));
  power_partner_model partner_u (.clk(clk), .rst_n(rst_n), .slow(slow),
    .master_stop_request(master_stop_request), .slave_stop_request(slave_stop_request),
    .regulator_stop_request(regulator_stop_request), .master_stop_ack(master_stop_ack),
    .slave_stop_ack(slave_stop_ack), .regulator_run_ready(regulator_run_ready),
    .regulator_stop_ready(regulator_stop_ready));

  // The clock never changes rate, as software must leave clocking alone in low power.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic poll(input logic [7:0] exp);
    for (int i = 0; i < 40; i++)
    begin
      bus(1'b0, addr_state, 32'h0);
      if (rd[7:0] === exp)
        break;
    end
    check("state", {24'h0, exp}, rd);
  endtask : poll

  task automatic ctl(input logic [1:0] run, input logic [2:0] halt);
    bus(1'b1, addr_control, (32'(run) << run_select_lsb) | (32'(halt) << halt_select_lsb));
  endtask : ctl

  task automatic sleep(input logic deep);
    @(posedge clk);
    deep_sleep_select <= deep;
    sleep_request <= 1'b1;
  endtask : sleep

  // The core stops sleeping as it takes the wake, so the mode is not entered again.
  task automatic wake();
    @(posedge clk);
    wake_interrupt <= 1'b1;
    sleep_request <= 1'b0;
    do @(posedge clk); while (cpu_clock_enable !== 1'b1);
    wake_interrupt <= 1'b0;
  endtask : wake

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic t_reset();
    poll(state_code_run);
    check("stack", 32'h0, vector_stack_address);
    check("pc", 32'h4, vector_pc_address);
    check("link", 32'hffffffff, link_register_init);
    bus(1'b0, addr_handshake, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask : t_reset

  task automatic t_very_low_power_run();
    ctl(run_select_vlp, halt_select_normal);
    poll(state_code_run);
    bus(1'b0, addr_control, 32'h0);
    check("refused", 32'h0, rd);
    bus(1'b1, addr_protection, 32'h1 << allow_vlp_bit);
    ctl(run_select_vlp, halt_select_normal);
    poll(state_code_very_low_power_run);
    check("flash", 32'h0, flash_program_allowed);
  endtask : t_very_low_power_run

  task automatic t_very_low_power_wait_very_low_power_halt();
    sleep(1'b0);
    poll(state_code_very_low_power_wait);
    wake();
    poll(state_code_very_low_power_run);
    sleep(1'b1);
    poll(state_code_very_low_power_halt);
    check("regulator", 32'h1, regulator_stop_request);
    wake();
    poll(state_code_very_low_power_run);
    ctl(run_select_normal, halt_select_normal);
    poll(state_code_run);
  endtask : t_very_low_power_wait_very_low_power_halt

  task automatic t_wait_debug();
    sleep(1'b0);
    poll(state_code_wait);
    check("cpu", 32'h0, cpu_clock_enable);
    check("bus", 32'h1, bus_clock_enable);
    check("siw", 32'h0, stop_in_wait_clock_enable);
    check("gen", 32'h1, clock_generator_enable);
    // A debug halt ends the core's sleep, so wait is not entered again.
    debug_enable <= 1'b1;
    debug_halt_request <= 1'b1;
    sleep_request <= 1'b0;
    do @(posedge clk); while (cpu_clock_enable !== 1'b1);
    check("debug bus", 32'h1, bus_clock_enable);
    debug_enable <= 1'b0;
    debug_halt_request <= 1'b0;
    wake();
    poll(state_code_run);
  endtask : t_wait_debug

  task automatic t_stops();
    sleep(1'b1);
    do @(posedge clk); while (bus_clock_enable !== 1'b0);
    poll(state_code_halt);
    check("gen off", 32'h0, clock_generator_enable);
    check("cpu off", 32'h0, cpu_clock_enable);
    wake();
    poll(state_code_run);
    ctl(run_select_normal, halt_select_vlp);
    sleep(1'b1);
    poll(state_code_very_low_power_halt);
    wake();
    poll(state_code_run);
  endtask : t_stops

  task automatic t_abort();
    ctl(run_select_normal, halt_select_normal);
    slow <= 1'b1;
    sleep(1'b1);
    do @(posedge clk); while (master_stop_request !== 1'b1);
    wake();
    poll(state_code_run);
    bus(1'b0, addr_control, 32'h0);
    check("aborted", 32'h1, rd[aborted_bit]);
    slow <= 1'b0;
  endtask : t_abort

  task automatic t_reset_very_low_power_run();
    ctl(run_select_vlp, halt_select_normal);
    poll(state_code_very_low_power_run);
    do_reset();
    poll(state_code_run);
    bus(1'b0, addr_control, 32'h0);
    check("control", 32'h0, rd);
  endtask : t_reset_very_low_power_run

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    {rst_n, read, write, sleep_request, deep_sleep_select, wake_interrupt} = 6'h0;
    {debug_enable, debug_halt_request, slow} = 3'h0;
    address = 4'h0;
    writedata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_very_low_power_run();
    t_very_low_power_wait_very_low_power_halt();
    t_wait_debug();
    t_stops();
    t_abort();
    t_reset_very_low_power_run();
    summarize();
  end
endmodule : tb_system_power_mode_controller
